/* ports_pkg.sv */
package ports_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int DIGIT_IDX_W = 4;

    localparam logic [ADDR_W-1:0] HV_PORT_DATA_ADDR = 16'hffd7;
    localparam logic [ADDR_W-1:0] STD_PORT_DATA_ADDR = 16'hffd8;
    localparam logic [ADDR_W-1:0] STD_PORT_DIRECTION_ADDR = 16'hffe8;
    localparam logic [ADDR_W-1:0] DISPLAY_DIGIT_CONTROL_ADDR = 16'hffc0;
    localparam logic [ADDR_W-1:0] DIGIT_START_REGISTER_ADDR = 16'hffc1;
    localparam logic [ADDR_W-1:0] DISPLAY_SEGMENT_CONTROL_ADDR = 16'hffc2;

    localparam logic [DATA_W-1:0] HV_PORT_DATA_RESET = 8'h00;
    localparam logic [DATA_W-1:0] STD_PORT_DATA_RESET = 8'h00;
    localparam logic [DATA_W-1:0] STD_PORT_DIRECTION_RESET = 8'h00;
    localparam logic [DATA_W-1:0] STD_PORT_DIRECTION_READ = 8'hff;
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;
    localparam logic [DIGIT_IDX_W-1:0] DIGIT_COUNT_RESET = 4'h0;

    localparam int DIGIT_COUNT_LSB = 0;
    localparam int DIGIT_ACTIVE_LSB = 4;
    localparam int DRIVE_ENABLE_BIT = 0;
    localparam int SCAN_RUNNING_BIT = 1;
    localparam int TAKEOVER_FLAG_BIT = 0;

    localparam logic [DIGIT_IDX_W-1:0] HV_FIRST_DIGIT = 4'h8;

    localparam int CLK_PERIOD_PS = 5000;
    localparam int DIGIT_SLOT_NS = 100000;
    localparam int DIGIT_SLOT_CYCLES = (DIGIT_SLOT_NS * 1000) / CLK_PERIOD_PS;
    localparam int SLOT_CNT_W = 16;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

    typedef struct packed {
        logic [DATA_W-1:0] data_out;
        logic [DATA_W-1:0] oe_n;
    } pin_drive_s;

endpackage : ports_pkg

/* display_digit_and_standard_ports.sv */
// Strobed register access was decided locally.
`timescale 1ns/1ps
module display_digit_and_standard_ports #(
    parameter int unsigned DIGIT_SLOT = ports_pkg::DIGIT_SLOT_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire ports_pkg::reg_req_s req,
    output logic [ports_pkg::DATA_W-1:0] rdata,
    input wire logic [ports_pkg::DATA_W-1:0] hv_pin_in,
    output ports_pkg::pin_drive_s hv_pin,
    input wire logic [ports_pkg::DATA_W-1:0] std_pin_in,
    output ports_pkg::pin_drive_s std_pin
);
    import ports_pkg::*;

    logic [DATA_W-1:0] hv_port_data_r;
    logic [DATA_W-1:0] hv_port_data_nxt;
    logic [DATA_W-1:0] std_port_data_r;
    logic [DATA_W-1:0] std_port_data_nxt;
    logic [DATA_W-1:0] std_port_direction_r;
    logic [DATA_W-1:0] std_port_direction_nxt;
    logic [DIGIT_IDX_W-1:0] digit_count_field_r;
    logic [DIGIT_IDX_W-1:0] digit_count_nxt;
    logic display_drive_enable_r;
    logic drive_enable_nxt;
    logic display_pin_takeover_flag_r;
    logic takeover_flag_nxt;
    logic [DIGIT_IDX_W-1:0] active_digit_r;
    logic [SLOT_CNT_W-1:0] slot_cnt_r;
    logic slot_tick;
    wire logic [DATA_W-1:0] digit_pin_mask;
    wire logic [DATA_W-1:0] hv_read;
    wire logic [DATA_W-1:0] hv_lane_out;
    wire logic [DATA_W-1:0] hv_lane_oe_n;
    wire logic [DATA_W-1:0] std_read;
    wire logic [DATA_W-1:0] std_lane_out;
    wire logic [DATA_W-1:0] std_lane_oe_n;
    logic [DATA_W-1:0] rdata_nxt;
    logic [DATA_W-1:0] rdata_r;

    logic wr_hv_data;
    logic wr_std_data;
    logic wr_std_dir;
    logic wr_digit_ctl;
    logic wr_start;
    logic wr_segment_ctl;

    assign wr_hv_data = req.wr && (req.addr == HV_PORT_DATA_ADDR);
    assign wr_std_data = req.wr && (req.addr == STD_PORT_DATA_ADDR);
    assign wr_std_dir = req.wr && (req.addr == STD_PORT_DIRECTION_ADDR);
    assign wr_digit_ctl = req.wr && (req.addr == DISPLAY_DIGIT_CONTROL_ADDR);
    assign wr_start = req.wr && (req.addr == DIGIT_START_REGISTER_ADDR);
    assign wr_segment_ctl = req.wr && (req.addr == DISPLAY_SEGMENT_CONTROL_ADDR);

    // Next values are formed once and shared by the registers and the pin flops,
    // so a port, count or flag write reaches the pins on the same edge that stores it.
    always_comb begin
        hv_port_data_nxt = wr_hv_data ? req.wdata : hv_port_data_r;
        std_port_data_nxt = wr_std_data ? req.wdata : std_port_data_r;
        std_port_direction_nxt = wr_std_dir ? req.wdata : std_port_direction_r;
        digit_count_nxt = wr_digit_ctl ?
            req.wdata[DIGIT_COUNT_LSB +: DIGIT_IDX_W] : digit_count_field_r;
        drive_enable_nxt = wr_start ? req.wdata[DRIVE_ENABLE_BIT] : display_drive_enable_r;
        takeover_flag_nxt = wr_segment_ctl ?
            req.wdata[TAKEOVER_FLAG_BIT] : display_pin_takeover_flag_r;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            hv_port_data_r <= HV_PORT_DATA_RESET;
        end else begin
            hv_port_data_r <= hv_port_data_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            std_port_data_r <= STD_PORT_DATA_RESET;
            std_port_direction_r <= STD_PORT_DIRECTION_RESET;
        end else begin
            std_port_data_r <= std_port_data_nxt;
            std_port_direction_r <= std_port_direction_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            digit_count_field_r <= DIGIT_COUNT_RESET;
            display_drive_enable_r <= 1'b0;
            display_pin_takeover_flag_r <= 1'b0;
        end else begin
            digit_count_field_r <= digit_count_nxt;
            display_drive_enable_r <= drive_enable_nxt;
            display_pin_takeover_flag_r <= takeover_flag_nxt;
        end
    end

    // The slot divider and the digit walk both sit idle until drive-enable is set.
    // Changing the digit count mid-scan reaches the walk at the next slot tick and the digit pins on the edge that stores it.
    assign slot_tick = display_drive_enable_r &&
        (slot_cnt_r == SLOT_CNT_W'(DIGIT_SLOT - 1));

    always_ff @(posedge core_clk) begin
        if (reset) begin
            slot_cnt_r <= '0;
        end else if (!display_drive_enable_r || slot_tick) begin
            slot_cnt_r <= '0;
        end else begin
            slot_cnt_r <= slot_cnt_r + SLOT_CNT_W'(1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            active_digit_r <= '0;
        end else if (!display_drive_enable_r) begin
            active_digit_r <= '0;
        end else if (slot_tick) begin
            if (active_digit_r >= digit_count_field_r) begin
                active_digit_r <= '0;
            end else begin
                active_digit_r <= active_digit_r + DIGIT_IDX_W'(1);
            end
        end
    end

    // Lane i of the high-voltage port carries digit 8 + i.
    // Pin flops see next data, flag and count, so such a write drives its pin on the edge that stores it; drive-enable lags one edge.
    for (genvar i = 0; i < DATA_W; i++) begin : g_hv_lane
        hv_pin_lane #(
            .LANE(i)
        ) hv_pin_lane_inst (
            .core_clk(core_clk),
            .reset(reset),
            .takeover_flag(display_pin_takeover_flag_r),
            .digit_count(digit_count_field_r),
            .takeover_flag_nxt(takeover_flag_nxt),
            .digit_count_nxt(digit_count_nxt),
            .drive_enable(display_drive_enable_r),
            .active_digit(active_digit_r),
            .data_bit(hv_port_data_r[i]),
            .data_bit_nxt(hv_port_data_nxt[i]),
            .pin_in(hv_pin_in[i]),
            .taken(digit_pin_mask[i]),
            .read_bit(hv_read[i]),
            .data_out(hv_lane_out[i]),
            .oe_n(hv_lane_oe_n[i])
        );
    end

    // Each standard port lane keeps its own synchroniser and read selection.
    for (genvar i = 0; i < DATA_W; i++) begin : g_std_lane
        std_pin_lane std_pin_lane_inst (
            .core_clk(core_clk),
            .reset(reset),
            .direction_bit(std_port_direction_r[i]),
            .direction_bit_nxt(std_port_direction_nxt[i]),
            .data_bit(std_port_data_r[i]),
            .data_bit_nxt(std_port_data_nxt[i]),
            .pin_in(std_pin_in[i]),
            .read_bit(std_read[i]),
            .data_out(std_lane_out[i]),
            .oe_n(std_lane_oe_n[i])
        );
    end

    always_comb begin
        rdata_nxt = UNMAPPED_READ;
        unique case (req.addr)
            HV_PORT_DATA_ADDR: begin
                rdata_nxt = hv_read;
            end
            STD_PORT_DATA_ADDR: begin
                rdata_nxt = std_read;
            end
            STD_PORT_DIRECTION_ADDR: begin
                rdata_nxt = STD_PORT_DIRECTION_READ;
            end
            DISPLAY_DIGIT_CONTROL_ADDR: begin
                rdata_nxt[DIGIT_COUNT_LSB +: DIGIT_IDX_W] = digit_count_field_r;
                rdata_nxt[DIGIT_ACTIVE_LSB +: DIGIT_IDX_W] = active_digit_r;
            end
            DIGIT_START_REGISTER_ADDR: begin
                rdata_nxt[DRIVE_ENABLE_BIT] = display_drive_enable_r;
                rdata_nxt[SCAN_RUNNING_BIT] = display_drive_enable_r && (|digit_pin_mask);
            end
            DISPLAY_SEGMENT_CONTROL_ADDR: begin
                rdata_nxt[TAKEOVER_FLAG_BIT] = display_pin_takeover_flag_r;
            end
            default: begin
                rdata_nxt = UNMAPPED_READ;
            end
        endcase
    end

    // Read data holds only in the cycle after the strobe, zero otherwise.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rdata_r <= '0;
        end else if (req.rd) begin
            rdata_r <= rdata_nxt;
        end else begin
            rdata_r <= '0;
        end
    end

    assign rdata = rdata_r;
    assign hv_pin = {hv_lane_out, hv_lane_oe_n};
    assign std_pin = {std_lane_out, std_lane_oe_n};

endmodule : display_digit_and_standard_ports

module hv_pin_lane #(
    parameter int unsigned LANE = 0
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic takeover_flag,
    input wire logic [ports_pkg::DIGIT_IDX_W-1:0] digit_count,
    input wire logic takeover_flag_nxt,
    input wire logic [ports_pkg::DIGIT_IDX_W-1:0] digit_count_nxt,
    input wire logic drive_enable,
    input wire logic [ports_pkg::DIGIT_IDX_W-1:0] active_digit,
    input wire logic data_bit,
    input wire logic data_bit_nxt,
    input wire logic pin_in,
    output logic taken,
    output logic read_bit,
    output logic data_out,
    output logic oe_n
);
    import ports_pkg::*;

    // The high-voltage port carries digits 8 to 15, one per lane.
    localparam logic [DIGIT_IDX_W-1:0] DIGIT_NUM = HV_FIRST_DIGIT + DIGIT_IDX_W'(LANE);

    logic sync1_r;
    logic sync2_r;
    logic taken_nxt;
    logic data_out_r;
    logic oe_n_r;

    // Only the second stage of the synchroniser is read by any logic.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
        end
    end

    // A lane is a digit pin whenever the flag is set and its digit is within the count, even before drive-enable.
    assign taken = takeover_flag && (DIGIT_NUM <= digit_count);
    assign taken_nxt = takeover_flag_nxt && (DIGIT_NUM <= digit_count_nxt);
    assign read_bit = taken ? data_bit : sync2_r;

    // A general pin drives high from a 1 and is released on a 0, so its level can be read.
    // The low level then comes from the board, not from this lane.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            data_out_r <= 1'b0;
            oe_n_r <= 1'b1;
        end else if (taken_nxt) begin
            data_out_r <= drive_enable && (active_digit == DIGIT_NUM);
            oe_n_r <= 1'b0;
        end else begin
            data_out_r <= data_bit_nxt;
            oe_n_r <= ~data_bit_nxt;
        end
    end

    assign data_out = data_out_r;
    assign oe_n = oe_n_r;

endmodule : hv_pin_lane

module std_pin_lane (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic direction_bit,
    input wire logic direction_bit_nxt,
    input wire logic data_bit,
    input wire logic data_bit_nxt,
    input wire logic pin_in,
    output logic read_bit,
    output logic data_out,
    output logic oe_n
);
    import ports_pkg::*;

    logic sync1_r;
    logic sync2_r;
    logic data_out_r;
    logic oe_n_r;

    // Only the second stage of the synchroniser is read by any logic.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
        end
    end

    // An output bit reads its stored data, so a loaded pin cannot upset a read-modify-write.
    assign read_bit = direction_bit ? data_bit :
        sync2_r;

    // Pins leave reset as released inputs.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            data_out_r <= 1'b0;
            oe_n_r <= 1'b1;
        end else begin
            data_out_r <= data_bit_nxt;
            oe_n_r <= ~direction_bit_nxt;
        end
    end

    assign data_out = data_out_r;
    assign oe_n = oe_n_r;

endmodule : std_pin_lane

/* ports_props.sv */
`timescale 1ns/1ps
module ports_props #(
    parameter int unsigned DIGIT_SLOT = 4
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire ports_pkg::reg_req_s req,
    input wire logic [ports_pkg::DATA_W-1:0] rdata,
    input wire logic [ports_pkg::DATA_W-1:0] hv_pin_in,
    input wire ports_pkg::pin_drive_s hv_pin,
    input wire logic [ports_pkg::DATA_W-1:0] std_pin_in,
    input wire ports_pkg::pin_drive_s std_pin
);
    import ports_pkg::*;
    localparam int SCAN_MAX = 200;
    logic [7:0] hv_r;
    logic [3:0] cnt_r;
    logic flag_r;
    logic en_r;
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    always_ff @(posedge core_clk) begin
        if (reset) begin
            hv_r <= 8'h00;
            cnt_r <= 4'h0;
            flag_r <= 1'b0;
            en_r <= 1'b0;
        end else if (req.wr) begin
            if (req.addr == HV_PORT_DATA_ADDR) hv_r <= req.wdata;
            if (req.addr == DISPLAY_DIGIT_CONTROL_ADDR) cnt_r <= req.wdata[3:0];
            if (req.addr == DISPLAY_SEGMENT_CONTROL_ADDR) flag_r <= req.wdata[0];
            if (req.addr == DIGIT_START_REGISTER_ADDR) en_r <= req.wdata[0];
        end
    end
    a_dir_sets_oe: assert property (req.wr && req.addr == STD_PORT_DIRECTION_ADDR
        |=> std_pin.oe_n == ~$past(req.wdata)) else $error("enable mismatch");
    a_data_drives_pin: assert property (req.wr && req.addr == STD_PORT_DATA_ADDR
        |=> std_pin.data_out == $past(req.wdata)) else $error("drive mismatch");
    a_dir_reads_ones: assert property (req.rd && req.addr == STD_PORT_DIRECTION_ADDR
        |=> rdata == 8'hff) else $error("direction read not all ones");
    a_input_reads_pin: assert property ($stable(std_pin_in) [*4] ##0
        (req.rd && req.addr == STD_PORT_DATA_ADDR)
        |=> (rdata & std_pin.oe_n) == ($past(std_pin_in) & std_pin.oe_n)) else $error("pin read");
    a_hv_general_io: assert property (!flag_r |-> hv_pin.oe_n == ~hv_r)
        else $error("general pin enable wrong");
    a_digit_reads_data: assert property (req.rd && req.addr == HV_PORT_DATA_ADDR
        && flag_r && cnt_r == 4'hf |=> rdata == hv_r) else $error("digit read wrong");
    a_scan_held_off: assert property ((flag_r && cnt_r == 4'hf && !en_r) [*2]
        |-> hv_pin.data_out == 8'h00) else $error("digit driven while disabled");
    a_scan_starts: assert property ($rose(en_r) && flag_r && cnt_r == 4'hf
        |-> ##[1:SCAN_MAX] hv_pin.data_out != 8'h00) else $error("scan never started");
    a_reset_values: assert property ($fell(reset) |-> std_pin.oe_n == 8'hff
        && std_pin.data_out == 8'h00 && hv_pin.data_out == 8'h00) else $error("reset state");
    c_digit_read: cover property (req.rd && req.addr == HV_PORT_DATA_ADDR && flag_r);
    c_scan_on: cover property ($rose(en_r) && flag_r);
    c_all_out: cover property (req.wr && req.addr == STD_PORT_DIRECTION_ADDR && req.wdata == 8'hff);
endmodule : ports_props

bind display_digit_and_standard_ports ports_props #(.DIGIT_SLOT(DIGIT_SLOT)) ports_props_inst (
    .core_clk(core_clk), .reset(reset), .req(req), .rdata(rdata), .hv_pin_in(hv_pin_in),
    .hv_pin(hv_pin), .std_pin_in(std_pin_in), .std_pin(std_pin));

/* pin_board.sv */
`timescale 1ns/1ps
module pin_board (
    input wire ports_pkg::pin_drive_s std_pin,
    input wire ports_pkg::pin_drive_s hv_pin,
    input wire logic [7:0] std_ext,
    input wire logic [7:0] hv_ext,
    output logic [7:0] std_lvl,
    output logic [7:0] hv_lvl
);
    import ports_pkg::*;
    // A released pin shows the board's own level, never a held copy of the last drive.
    assign std_lvl = (std_pin.data_out & ~std_pin.oe_n) | (std_ext & std_pin.oe_n);
    assign hv_lvl = (hv_pin.data_out & ~hv_pin.oe_n) | (hv_ext & hv_pin.oe_n);
endmodule : pin_board

/* tb_display_digit_and_standard_ports.sv */
`timescale 1ns/1ps
module tb_display_digit_and_standard_ports;
    import ports_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    reg_req_s req = '0;
    logic [7:0] rdata;
    logic [7:0] hv_lvl;
    logic [7:0] std_lvl;
    logic [7:0] std_ext = 8'h00;
    logic [7:0] hv_ext = 8'h00;
    pin_drive_s hv_pin;
    pin_drive_s std_pin;
    logic [31:0] seed = 32'h9ca17a25;
    int errors = 0;
    int total_checks = 0;
    int cycles = 0;
    int hv_m;
    int std_m;
    int dir_m;
    int tmp;
    always #2.5 core_clk = ~core_clk;
    display_digit_and_standard_ports #(.DIGIT_SLOT(4)) display_digit_and_standard_ports_inst (
        .core_clk(core_clk), .reset(reset), .req(req), .rdata(rdata), .hv_pin_in(hv_lvl),
        .hv_pin(hv_pin), .std_pin_in(std_lvl), .std_pin(std_pin));
    pin_board pin_board_inst (.std_pin(std_pin), .hv_pin(hv_pin), .std_ext(std_ext),
        .hv_ext(hv_ext), .std_lvl(std_lvl), .hv_lvl(hv_lvl));
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : rnd
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge core_clk);
        req.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge core_clk);
        req.rd <= 1'b0;
        @(negedge core_clk);
        check(rdata, exp);
    endtask : rd
    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles > 3000) begin
            errors++;
            end_of_test();
        end
    end
    initial begin
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        std_ext <= rnd();
        hv_ext <= rnd();
        repeat (4) @(posedge core_clk);
        check(hv_pin.oe_n, 8'hff);
        rd(HV_PORT_DATA_ADDR, hv_ext);
        rd(STD_PORT_DATA_ADDR, std_ext);
        rd(STD_PORT_DIRECTION_ADDR, 8'hff);
        rd(16'h0000, UNMAPPED_READ);
        for (int i = 0; i < 24; i++) begin
            dir_m = rnd();
            std_m = rnd();
            std_ext <= rnd();
            wr(STD_PORT_DIRECTION_ADDR, 8'(dir_m));
            wr(STD_PORT_DATA_ADDR, 8'(std_m));
            @(negedge core_clk);
            check(std_pin.oe_n, 8'(~dir_m));
            check(std_pin.data_out, 8'(std_m));
            rd(STD_PORT_DATA_ADDR, 8'((dir_m & std_m) | (~dir_m & std_ext)));
        end
        hv_m = rnd();
        wr(HV_PORT_DATA_ADDR, 8'(hv_m));
        @(negedge core_clk);
        check(hv_pin.oe_n, 8'(~hv_m));
        repeat (2) @(posedge core_clk);
        rd(HV_PORT_DATA_ADDR, 8'(hv_m | (hv_ext & ~hv_m)));
        wr(DISPLAY_DIGIT_CONTROL_ADDR, 8'h0f);
        wr(DISPLAY_SEGMENT_CONTROL_ADDR, 8'h01);
        @(negedge core_clk);
        check(hv_pin.data_out, 8'h00);
        rd(HV_PORT_DATA_ADDR, 8'(hv_m));
        wr(DIGIT_START_REGISTER_ADDR, 8'h01);
        tmp = 0;
        while (hv_pin.data_out === 8'h00 && tmp < 200) begin
            @(negedge core_clk);
            tmp++;
        end
        check(8'($countones(hv_pin.data_out)), 8'h01);
        rd(DIGIT_START_REGISTER_ADDR, 8'h03);
        rd(DISPLAY_SEGMENT_CONTROL_ADDR, 8'h01);
        rd(HV_PORT_DATA_ADDR, 8'(hv_m));
        wr(DISPLAY_SEGMENT_CONTROL_ADDR, 8'h00);
        @(negedge core_clk);
        check(hv_pin.oe_n, 8'(~hv_m));
        @(posedge core_clk);
        reset <= 1'b1;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        @(negedge core_clk);
        check(std_pin.oe_n, 8'hff);
        check(std_pin.data_out, STD_PORT_DATA_RESET);
        check(hv_pin.data_out, HV_PORT_DATA_RESET);
        wr(STD_PORT_DIRECTION_ADDR, 8'hff);
        rd(STD_PORT_DATA_ADDR, 8'h00);
        end_of_test();
    end
endmodule : tb_display_digit_and_standard_ports
